// File: design/mkps_decode.sv
// Row decoder: active column and low row lines to a key index
`include "mkps_map.svh"
`default_nettype none
module mkps_decode
    import mkps_pkg::*;
(
    input wire logic [1:0] col,
    input wire logic [3:0] rows_n,
    output mkps_hit_t hit
);
    // Highest row wins when several keys share a column
    always_comb begin
        hit.valid = 1'b0;
        hit.key = 4'h0;
        for (int r = 0; r < `MKPS_NROW; r++) begin
            if (!rows_n[r]) begin
                hit.valid = 1'b1;
                hit.key = {col, r[1:0]};
            end
        end
        if (rows_n == `MKPS_ROWS_IDLE) begin
            hit.valid = 1'b0;
        end
    end
endmodule : mkps_decode
`default_nettype wire

// File: design/mkps_map.svh
// Constants for the matrix keypad scanner: port layout, timing and reset values
`ifndef MKPS_MAP_SVH
`define MKPS_MAP_SVH
`define MKPS_PORT_W 8
`define MKPS_NCOL 4
`define MKPS_NROW 4
`define MKPS_COL_LSB 0
`define MKPS_ROW_LSB 4
`define MKPS_KEY_W 4
`define MKPS_COL_FIRST 2'h3
`define MKPS_COL_LAST 2'h0
`define MKPS_ROWS_IDLE 4'hF
`define MKPS_SETTLE_NS 1000
`define MKPS_CLK_MHZ 250
`define MKPS_STABLE_SCANS 3
`define MKPS_CNT_W 16
`define MKPS_SCAN_W 8
`endif

// File: design/mkps_pkg.sv
// Types shared by the matrix keypad scanner
`default_nettype none
package mkps_pkg;
    typedef struct packed {
        logic [3:0] key;
        logic valid;
    } mkps_hit_t;
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } mkps_drive_t;
    typedef enum logic [1:0] {MKPS_SETTLE, MKPS_SAMPLE} mkps_phase_t;
endpackage : mkps_pkg
`default_nettype wire

// File: design/mkps_scanner.sv
// Matrix keypad scanner top: column drive, row sense, debounce and key report
`include "mkps_map.svh"
`default_nettype none
module mkps_scanner
    import mkps_pkg::*;
#(
    parameter int SETTLE_NS = `MKPS_SETTLE_NS,
    parameter int STABLE_SCANS = `MKPS_STABLE_SCANS
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic scan_en,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    input wire logic [7:0] port_in,
    output logic [7:0] port_out,
    output logic [7:0] port_oe,
    output logic [7:0] gpio_in,
    output logic [3:0] key_index,
    output logic key_pressed
);
    // ****************************************
    // Timing
    // ****************************************
    localparam int SETTLE_CYC_RAW = (SETTLE_NS * `MKPS_CLK_MHZ + 999) / 1000;
    localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
    localparam logic [`MKPS_CNT_W-1:0] SETTLE_LAST = `MKPS_CNT_W'(SETTLE_CYC - 1);
    localparam logic [`MKPS_SCAN_W-1:0] STABLE_N = `MKPS_SCAN_W'(STABLE_SCANS);

    // ****************************************
    // State
    // ****************************************
    mkps_phase_t phase_q, phase_d;
    logic [1:0] col_q, col_d;
    logic [`MKPS_CNT_W-1:0] cnt_q, cnt_d;
    mkps_hit_t scan_hit_q, scan_hit_d;
    mkps_hit_t last_hit_q, last_hit_d;
    logic [`MKPS_SCAN_W-1:0] same_q, same_d;
    logic [3:0] key_q, key_d;
    logic pressed_q, pressed_d;
    mkps_drive_t drv_q, drv_d;
    logic [7:0] gin_q, gin_d;
    logic [3:0] rows_n;
    mkps_hit_t col_hit;
    mkps_hit_t verdict;

    assign rows_n = port_in[`MKPS_ROW_LSB +: `MKPS_NROW];

    mkps_decode u_decode (
        .col(col_q),
        .rows_n(rows_n),
        .hit(col_hit)
    );

    // ****************************************
    // Pin drive
    // ****************************************
    always_comb begin
        drv_d.out = gpio_out;
        drv_d.oe = gpio_oe;
        gin_d = port_in;
        if (scan_en) begin
            for (int c = 0; c < `MKPS_NCOL; c++) begin
                drv_d.out[`MKPS_COL_LSB + c] = (col_d != c[1:0]);
                drv_d.oe[`MKPS_COL_LSB + c] = 1'b1;
            end
            drv_d.out[`MKPS_ROW_LSB +: `MKPS_NROW] = 4'h0;
            drv_d.oe[`MKPS_ROW_LSB +: `MKPS_NROW] = 4'h0;
        end
    end

    // ****************************************
    // Scan sequencer and debounce
    // ****************************************
    always_comb begin
        phase_d = phase_q;
        col_d = col_q;
        cnt_d = cnt_q;
        scan_hit_d = scan_hit_q;
        last_hit_d = last_hit_q;
        same_d = same_q;
        key_d = key_q;
        pressed_d = pressed_q;
        // Scan result so far, this column included
        verdict = (col_hit.valid && !scan_hit_q.valid) ? col_hit : scan_hit_q;
        if (!scan_en) begin
            phase_d = MKPS_SETTLE;
            col_d = `MKPS_COL_FIRST;
            cnt_d = '0;
            scan_hit_d = '0;
            same_d = '0;
            pressed_d = 1'b0;
        end else begin
            unique case (phase_q)
                MKPS_SETTLE: begin
                    // Rows read only after the column has had time to settle
                    if (cnt_q == SETTLE_LAST) begin
                        phase_d = MKPS_SAMPLE;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                MKPS_SAMPLE: begin
                    cnt_d = '0;
                    phase_d = MKPS_SETTLE;
                    // First hit in a scan wins, i.e. the highest key
                    scan_hit_d = verdict;
                    if (col_q == `MKPS_COL_LAST) begin
                        col_d = `MKPS_COL_FIRST;
                        scan_hit_d = '0;
                        // Verdict compared before the scan record is cleared
                        if (verdict.valid && verdict == last_hit_q) begin
                            if (same_q != STABLE_N) begin
                                same_d = same_q + 1'b1;
                            end
                        end else begin
                            same_d = verdict.valid ? `MKPS_SCAN_W'(1) : '0;
                        end
                        last_hit_d = verdict;
                        if (!verdict.valid) begin
                            pressed_d = 1'b0;
                        end else if (same_d >= STABLE_N) begin
                            pressed_d = 1'b1;
                            key_d = last_hit_d.key;
                        end
                    end else begin
                        col_d = col_q - 1'b1;
                    end
                end
                default: begin
                    phase_d = MKPS_SETTLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= MKPS_SETTLE;
            col_q <= `MKPS_COL_FIRST;
            cnt_q <= '0;
            scan_hit_q <= '0;
            last_hit_q <= '0;
            same_q <= '0;
            key_q <= 4'h0;
            pressed_q <= 1'b0;
            drv_q <= '0;
            gin_q <= 8'h00;
        end else begin
            phase_q <= phase_d;
            col_q <= col_d;
            cnt_q <= cnt_d;
            scan_hit_q <= scan_hit_d;
            last_hit_q <= last_hit_d;
            same_q <= same_d;
            key_q <= key_d;
            pressed_q <= pressed_d;
            drv_q <= drv_d;
            gin_q <= gin_d;
        end
    end

    assign port_out = drv_q.out;
    assign port_oe = drv_q.oe;
    assign gpio_in = gin_q;
    assign key_index = key_q;
    assign key_pressed = pressed_q;
endmodule : mkps_scanner
`default_nettype wire

// File: verif/mkps_keypad.sv
// Passive 4x4 switch matrix, pull-ups on every line
`default_nettype none
module mkps_keypad (
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_oe,
    input wire logic [15:0] keys,
    output logic [7:0] port_in
);
    timeunit 1ns / 1ps;
    always_comb begin
        port_in = ~port_oe | port_out;
        for (int r = 0; r < 4; r++) begin
            for (int c = 0; c < 4; c++) begin
                // A closed switch pulls its row to the low column
                if (keys[c * 4 + r] && !port_in[c] && !port_oe[4 + r]) begin
                    port_in[4 + r] = 1'b0;
                end
            end
        end
    end
endmodule : mkps_keypad
`default_nettype wire

// File: verif/mkps_properties.sv
// Port checks for the keypad scanner
`default_nettype none
module mkps_properties #(
    parameter int SETTLE_NS = 1000,
    parameter int STABLE_SCANS = 3
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic scan_en,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    input wire logic [7:0] port_in,
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_oe,
    input wire logic [7:0] gpio_in,
    input wire logic [3:0] key_index,
    input wire logic key_pressed
);
    localparam int SETTLE_CYC = (SETTLE_NS * 250 + 999) / 1000;
    localparam int PERIOD = ((SETTLE_CYC < 1) ? 1 : SETTLE_CYC) + 1;
    logic [15:0] hold_q;
    logic [3:0] col_q;
    logic armed_q;
    default clocking dck @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // Armed on entering column 2, so only the first column after scanning starts is not timed
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {hold_q, col_q, armed_q} <= '0;
        end else begin
            col_q <= port_out[3:0];
            hold_q <= (port_out[3:0] != col_q) ? 16'h1 : hold_q + 16'h1;
            armed_q <= port_oe == 8'h0F && (armed_q || port_out[3:0] == 4'hB);
        end
    end
    sequence s_scan;
        port_oe == 8'h0F && $past(port_oe) == 8'h0F;
    endsequence
    sequence s_step;
        port_out[3:0] != col_q;
    endsequence
    oe_scan_a: assert property (scan_en && $past(scan_en) && $past(resetn)
        |-> port_oe == 8'h0F) else $error("bad scan enables");
    one_col_a: assert property (port_oe == 8'h0F
        |-> $onehot(~port_out[3:0]) && port_out[7:4] == 4'h0) else $error("bad column drive");
    col_order_a: assert property (s_scan ##0 s_step
        |-> port_out[3:0] == {col_q[0], col_q[3:1]}) else $error("bad column order");
    col_hold_a: assert property ((armed_q && port_oe == 8'h0F) ##0 s_step
        |-> hold_q == PERIOD) else $error("bad column period");
    gpio_pass_a: assert property (!$past(scan_en) && $past(resetn)
        |-> port_out == $past(gpio_out) && port_oe == $past(gpio_oe)) else $error("bad gpio");
    gpio_echo_a: assert property ($past(resetn) |-> gpio_in == $past(port_in))
        else $error("bad gpio input");
    key_off_a: assert property (!$past(scan_en) |-> !key_pressed)
        else $error("flag without scan");
    key_hold_a: assert property (key_pressed && $past(key_pressed) |-> $stable(key_index))
        else $error("index moved");
endmodule : mkps_properties
bind mkps_scanner mkps_properties #(.SETTLE_NS(SETTLE_NS), .STABLE_SCANS(STABLE_SCANS)) u_props (
    .mclk, .resetn, .scan_en, .gpio_out, .gpio_oe, .port_in, .port_out, .port_oe, .gpio_in,
    .key_index, .key_pressed);
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench: scanner against a switch matrix
`default_nettype none
module testbench;
    timeunit 1ns / 1ps;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic scan_en = 1'b0;
    logic [7:0] gpio_out = 8'h00;
    logic [7:0] gpio_oe = 8'h80;
    logic [15:0] keys = 16'h0000;
    logic [7:0] port_in, port_out, port_oe, gpio_in;
    logic [3:0] key_index;
    logic key_pressed;
    int error_cnt = 0;
    int checked = 0;
    mkps_scanner #(.SETTLE_NS(32), .STABLE_SCANS(2)) u_dut (.mclk, .resetn, .scan_en,
        .gpio_out, .gpio_oe, .port_in, .port_out, .port_oe, .gpio_in, .key_index, .key_pressed);
    mkps_keypad u_pad (.port_out, .port_oe, .keys, .port_in);
    initial forever #2 mclk = ~mclk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("checked %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task automatic wait_key(input logic lvl);
        for (int i = 0; i < 600 && key_pressed !== lvl; i++) @(posedge mclk) #1;
    endtask : wait_key
    task automatic press(input logic [15:0] m);
        int exp = 0;
        keys = m;
        // Higher column wins, then higher row: the top index
        for (int k = 0; k < 16; k++) if (m[k]) exp = k;
        wait_key(1'b1);
        check(key_index, exp[3:0], "key index");
        check(key_pressed, 1'b1, "key flag");
        keys = 16'h0000;
        wait_key(1'b0);
        check(key_pressed, 1'b0, "release flag");
    endtask : press
    initial begin
        void'($urandom(32'h2DE5));
        repeat (12) @(posedge mclk);
        #1 resetn = 1'b1;
        for (int i = 0; i < 8; i++) begin
            gpio_out = 8'($urandom);
            gpio_oe = 8'($urandom) | 8'h80;
            repeat (2) @(posedge mclk) #1;
            check(gpio_in, ~gpio_oe | gpio_out, "gpio echo");
        end
        scan_en = 1'b1;
        for (int k = 0; k < 16; k++) press(16'h1 << k);
        for (int i = 0; i < 6; i++) press(16'($urandom) | 16'h1);
        keys = 16'h0100;
        wait_key(1'b1);
        scan_en = 1'b0;
        repeat (2) @(posedge mclk) #1;
        check(key_pressed, 1'b0, "abort flag");
        check(key_index, 4'h8, "kept index");
        test_done();
    end
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
endmodule : testbench
`default_nettype wire
